/* File: rtl/tra_pkg.sv */
package tra_pkg;
  // op-code kinds as decoded from / handed to the ring serializer
  localparam logic [2:0] OP_IDLE = 3'h0;
  localparam logic [2:0] OP_TOKEN = 3'h1;
  localparam logic [2:0] OP_FLUSH = 3'h2;
  localparam logic [2:0] OP_XON = 3'h3;
  localparam logic [2:0] OP_XOFF = 3'h4;
  localparam int ID_W = 2;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 8;
  // token timeout, nanoseconds and cycles at 250 MHz
  localparam int CLK_NS = 4;
  localparam int TOKEN_TIMEOUT_NS = 400;
  localparam int TOKEN_TIMEOUT_CYC = TOKEN_TIMEOUT_NS / CLK_NS;
  localparam int TMR_W = 16;
  localparam logic [15:0] PAUSE_MAX = 16'hFFFF;
  // frame kinds carried on the receive-data side
  localparam logic [1:0] KIND_PKT = 2'h0;
  localparam logic [1:0] KIND_XOFF = 2'h1;
  localparam logic [1:0] KIND_XON = 2'h2;
  typedef enum logic [2:0] {
    TRA_FLUSH = 3'b000,
    TRA_WAIT_IDLE = 3'b001,
    TRA_SEND_IDLE = 3'b011,
    TRA_NORMAL = 3'b010,
    TRA_TRANSFER_STATE = 3'b110
  } tra_state_t;
endpackage

/* File: rtl/tra_fifo.sv */
`timescale 1ns/1ps
module tra_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp;
  logic [AW:0] rp;
  logic full;
  logic empty;
  assign full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
  assign empty = (wp == rp);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rp[AW-1:0]];
  // write pointer and storage
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wp <= '0;
    end else if (in_valid && !full) begin
      wp <= wp + 1'b1;
    end
  end
  always_ff @(posedge mclk) begin
    if (in_valid && !full) begin
      mem[wp[AW-1:0]] <= in_data;
    end
  end
  // read pointer
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rp <= '0;
    end else if (out_ready && !empty) begin
      rp <= rp + 1'b1;
    end
  end
endmodule

/* File: rtl/tra_arbiter.sv */
`timescale 1ns/1ps
// Overview of operation
// (R01) normal state forwards each received op-code, token passes when idle; code sends idle instead of a returned own xon or of any xon while congested
// (R02) master issues the token on idle after the election
// (R03) receive-data drivers are off in the normal state
// (R04) transfer state drives one packet and/or one pause frame; code can drive both an xoff and an xon frame in one transfer
// (R05) idle op-codes go out throughout the transfer state
// (R06) token goes out after the transfer finishes
// (R07) xoff op-code sent when congested in the normal state
// (R08) xon op-code sent when congestion ends in the normal state
// (R09) election starts in flush-sending state sending flush continuously
// (R10) flush state left only on flush with id not above own
// (R11) own flush returned: idle-sending state sending idle
// (R12) lower foreign flush: wait for idle then normal state
// (R13) winning the election counts as token received
// (R14) pending flag raised when any frame waits to be sent
// (R15) election starts after reset and on arbitration enable
// (R16) token timeout flagged while waiting too long for token
// (R17) own xon sent and own xon returned are tracked
// (R18) received flush classified as own or foreign by id
// (R19) done pulses for pause-on and pause-off frames
// (R20) congested with token sends max pause frame, no op-code
// (R21) congestion end sends own xon and waits for its return
// (R22) timeout with pending data sends flush to restart
// (R23) flush in transfer state restarts election after transfer
module tra_arbiter
  import tra_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // configuration
  input wire logic [ID_W-1:0] package_identifier,
  input wire logic arbitration_enable_event,
  input wire logic congested,
  // ring op-code in, decoded by the serializer
  input wire logic ring_opcode_valid,
  input wire logic [2:0] ring_opcode_in,
  input wire logic [ID_W-1:0] ring_id_in,
  // ring op-code out
  output logic [2:0] ring_opcode_out,
  output logic [ID_W-1:0] ring_id_out,
  // packet data to send
  input wire logic pkt_valid,
  output logic pkt_ready,
  input wire logic [DATA_W-1:0] pkt_data,
  input wire logic pkt_last,
  // receive-data lines
  output logic [DATA_W-1:0] rxd_out,
  output logic rxd_oe,
  output logic [1:0] rxd_kind,
  output logic [15:0] rxd_pause_time,
  // status
  output logic arbitration_master,
  output logic transmit_pending,
  output logic token_timeout,
  output logic pause_on_frame_done,
  output logic pause_off_frame_done,
  output logic own_resume_opcode_sent,
  output logic own_resume_opcode_returned
);
  tra_state_t state;
  logic [DATA_W:0] f_data;
  logic f_valid;
  logic f_ready;
  logic f_in_ready;
  logic tok, idle_ev, flush_ev, foreign_flush_received, own_flush_returned;
  logic flush_not_above, xon_ev, xoff_ev;
  logic pend_xoff, pend_xon, cong_d, waiting_xon, flush_pending;
  logic pkt_done_flag, pkt_active;
  logic [TMR_W-1:0] tmr;
  logic fifo_in_valid;
  logic transfer_state_done;

  assign fifo_in_valid = pkt_valid;
  assign pkt_ready = f_in_ready;

  tra_fifo #(.WIDTH(DATA_W + 1), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .reset_n(reset_n),
    .in_valid(fifo_in_valid),
    .in_ready(f_in_ready),
    .in_data({pkt_last, pkt_data}),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  // received op-code decode
  assign tok = ring_opcode_valid && ring_opcode_in == OP_TOKEN;
  assign idle_ev = ring_opcode_valid && ring_opcode_in == OP_IDLE;
  assign flush_ev = ring_opcode_valid && ring_opcode_in == OP_FLUSH;
  assign xon_ev = ring_opcode_valid && ring_opcode_in == OP_XON;
  assign xoff_ev = ring_opcode_valid && ring_opcode_in == OP_XOFF;
  assign own_flush_returned = flush_ev
      && ring_id_in == package_identifier; // R18
  assign foreign_flush_received = flush_ev
      && ring_id_in != package_identifier; // R18
  assign flush_not_above = flush_ev
      && ring_id_in <= package_identifier; // R10
  // frame drain: one byte a cycle while packet phase runs
  assign f_ready = (state == TRA_TRANSFER_STATE) && pkt_active;
  assign transfer_state_done = !pkt_active && !pend_xoff && !pend_xon
      && (pkt_done_flag || !f_valid);

  // pending transmit indication
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      transmit_pending <= 1'b0;
    end else begin
      transmit_pending <= f_valid || pend_xoff || pend_xon; // R14
    end
  end

  // congestion tracking and pause frame requests
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cong_d <= 1'b0;
      pend_xoff <= 1'b0;
      pend_xon <= 1'b0;
      waiting_xon <= 1'b0;
      own_resume_opcode_returned <= 1'b0;
    end else begin
      cong_d <= congested;
      own_resume_opcode_returned <= xon_ev
          && ring_id_in == package_identifier; // R17
      if (state == TRA_TRANSFER_STATE && rxd_kind == KIND_XOFF && rxd_oe) begin
        pend_xoff <= 1'b0;
      end else if (congested && !cong_d && state == TRA_TRANSFER_STATE) begin
        pend_xoff <= 1'b1; // R20
      end else if (xoff_ev && state == TRA_TRANSFER_STATE) begin
        pend_xoff <= 1'b1;
      end
      if (waiting_xon && xon_ev
          && ring_id_in == package_identifier) begin
        pend_xon <= 1'b1; // returning own xon beats the clear
      end else if (state == TRA_TRANSFER_STATE && rxd_kind == KIND_XON && rxd_oe) begin
        pend_xon <= 1'b0;
      end
      if (!congested && cong_d) begin
        waiting_xon <= 1'b1; // R21
      end else if (xon_ev && (ring_id_in <= package_identifier)) begin
        waiting_xon <= 1'b0;
      end else if (congested) begin
        waiting_xon <= 1'b0;
      end
    end
  end

  // token timeout timer, runs in the normal state while pending and not holding token
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tmr <= '0;
      token_timeout <= 1'b0;
    end else begin
      token_timeout <= 1'b0;
      if (state != TRA_NORMAL || !transmit_pending || tok) begin
        tmr <= '0;
      end else if (tmr == TMR_W'(TOKEN_TIMEOUT_CYC - 1)) begin
        tmr <= '0;
        token_timeout <= 1'b1; // R16
      end else begin
        tmr <= tmr + 1'b1;
      end
    end
  end

  // arbitration state machine
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state <= TRA_FLUSH; // R15
      arbitration_master <= 1'b0;
      flush_pending <= 1'b0;
    end else begin
      if (state == TRA_TRANSFER_STATE && flush_ev) begin
        flush_pending <= 1'b1; // R23
      end else if (state != TRA_TRANSFER_STATE) begin
        flush_pending <= 1'b0;
      end
      if (arbitration_enable_event) begin
        state <= TRA_FLUSH; // R15
        arbitration_master <= 1'b0;
      end else begin
        case (state)
          TRA_FLUSH: begin
            if (own_flush_returned) begin
              state <= TRA_SEND_IDLE; // R11
              arbitration_master <= 1'b1;
            end else if (flush_not_above) begin
              state <= TRA_WAIT_IDLE; // R12
            end
          end
          TRA_WAIT_IDLE: begin
            if (idle_ev) begin
              state <= TRA_NORMAL; // R12
            end
          end
          TRA_SEND_IDLE: begin
            if (idle_ev && transmit_pending) begin
              state <= TRA_TRANSFER_STATE; // R13
            end else if (idle_ev || own_flush_returned) begin
              state <= TRA_NORMAL; // R02
            end
          end
          TRA_NORMAL: begin
            if (flush_ev || token_timeout) begin
              state <= TRA_FLUSH; // R22
              arbitration_master <= 1'b0;
            end else if (tok && transmit_pending) begin
              state <= TRA_TRANSFER_STATE;
            end
          end
          TRA_TRANSFER_STATE: begin
            if (transfer_state_done) begin
              state <= (flush_pending || flush_ev) ? TRA_FLUSH
                  : TRA_NORMAL; // R23
            end
          end
          default: state <= TRA_FLUSH;
        endcase
      end
    end
  end

  // receive-data driver: pause frame first, then one packet
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rxd_out <= '0;
      rxd_oe <= 1'b0;
      rxd_kind <= KIND_PKT;
      rxd_pause_time <= '0;
      pkt_active <= 1'b0;
      pkt_done_flag <= 1'b0;
      pause_on_frame_done <= 1'b0;
      pause_off_frame_done <= 1'b0;
    end else begin
      pause_on_frame_done <= 1'b0;
      pause_off_frame_done <= 1'b0;
      rxd_oe <= 1'b0; // R03
      if (state != TRA_TRANSFER_STATE) begin
        pkt_done_flag <= 1'b0;
        pkt_active <= 1'b0;
      end else if (pend_xoff && !pkt_active && !rxd_oe) begin
        rxd_oe <= 1'b1; // R04
        rxd_kind <= KIND_XOFF;
        rxd_pause_time <= PAUSE_MAX; // R20
        pause_on_frame_done <= 1'b1; // R19
      end else if (pend_xon && !pkt_active && !rxd_oe) begin
        rxd_oe <= 1'b1; // R04
        rxd_kind <= KIND_XON;
        rxd_pause_time <= 16'h0000;
        pause_off_frame_done <= 1'b1; // R19
      end else if (!pkt_done_flag && f_valid && !pkt_active) begin
        pkt_active <= 1'b1; // R04
      end else if (pkt_active && f_valid) begin
        rxd_oe <= 1'b1;
        rxd_kind <= KIND_PKT;
        rxd_out <= f_data[DATA_W-1:0];
        if (f_data[DATA_W]) begin
          pkt_active <= 1'b0;
          pkt_done_flag <= 1'b1;
        end
      end
    end
  end

  // ring op-code output
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ring_opcode_out <= OP_FLUSH;
      ring_id_out <= '0;
      own_resume_opcode_sent <= 1'b0;
    end else begin
      own_resume_opcode_sent <= 1'b0;
      ring_id_out <= package_identifier;
      case (state)
        TRA_FLUSH: ring_opcode_out <= OP_FLUSH; // R09
        TRA_WAIT_IDLE: ring_opcode_out <= OP_IDLE;
        TRA_SEND_IDLE: begin
          // election win acts as token: kept while data waits
          if (idle_ev && !transmit_pending) begin
            ring_opcode_out <= OP_TOKEN; // R02
          end else begin
            ring_opcode_out <= OP_IDLE; // R11 R13
          end
        end
        TRA_TRANSFER_STATE: begin
          if (transfer_state_done) begin
            ring_opcode_out <= OP_TOKEN; // R06
          end else begin
            ring_opcode_out <= OP_IDLE; // R05
          end
        end
        TRA_NORMAL: begin
          if (token_timeout) begin
            ring_opcode_out <= OP_FLUSH; // R22
          end else if (congested && !cong_d) begin
            ring_opcode_out <= OP_XOFF; // R07
          end else if (!congested && cong_d) begin
            ring_opcode_out <= OP_XON; // R08
            own_resume_opcode_sent <= 1'b1; // R17
          end else if (tok && transmit_pending) begin
            ring_opcode_out <= OP_IDLE;
          end else if (ring_opcode_valid) begin
            ring_opcode_out <= ring_opcode_in; // R01
            ring_id_out <= ring_id_in;
            if (xon_ev && (congested || ring_id_in == package_identifier)) begin
              ring_opcode_out <= OP_IDLE;
            end
          end else begin
            ring_opcode_out <= OP_IDLE;
          end
        end
        default: ring_opcode_out <= OP_IDLE;
      endcase
    end
  end

  a_flush_sent: assert property ( // R09
      @(posedge mclk) disable iff (!reset_n)
      state == TRA_FLUSH && !token_timeout |=> ring_opcode_out == OP_FLUSH
      || $past(state) != TRA_FLUSH)
    else $error("flush not sent in flush state");
  a_rxd_quiet: assert property ( // R03
      @(posedge mclk) disable iff (!reset_n)
      $past(state) != TRA_TRANSFER_STATE |-> !rxd_oe)
    else $error("rxd driven outside transfer");
  a_xoff_max: assert property ( // R20
      @(posedge mclk) disable iff (!reset_n)
      rxd_oe && rxd_kind == KIND_XOFF |-> rxd_pause_time == PAUSE_MAX)
    else $error("pause frame time wrong");
  a_own_flush: assert property ( // R11
      @(posedge mclk) disable iff (!reset_n)
      state == TRA_FLUSH && own_flush_returned && !arbitration_enable_event
      |=> state == TRA_SEND_IDLE && arbitration_master)
    else $error("own flush not handled");
  a_low_flush: assert property ( // R12
      @(posedge mclk) disable iff (!reset_n)
      state == TRA_FLUSH && foreign_flush_received && flush_not_above
      && !arbitration_enable_event |=> state == TRA_WAIT_IDLE)
    else $error("lower flush not handled");
  a_enable_elect: assert property ( // R15
      @(posedge mclk) disable iff (!reset_n)
      arbitration_enable_event |=> state == TRA_FLUSH)
    else $error("enable did not restart election");
  a_xon_done: assert property ( // R19
      @(posedge mclk) disable iff (!reset_n)
      pause_off_frame_done |-> rxd_oe && rxd_kind == KIND_XON)
    else $error("pause off done without frame");
  a_master_token: assert property ( // R02
      @(posedge mclk) disable iff (!reset_n)
      state == TRA_SEND_IDLE && idle_ev && !transmit_pending
      |=> ring_opcode_out == OP_TOKEN)
    else $error("master did not issue token");
  a_win_transfer_state: assert property ( // R13
      @(posedge mclk) disable iff (!reset_n)
      state == TRA_SEND_IDLE && idle_ev && transmit_pending
      && !arbitration_enable_event |=> state == TRA_TRANSFER_STATE)
    else $error("election won with data but no transfer");
  c_transfer_state: cover property (@(posedge mclk) state == TRA_TRANSFER_STATE);
  c_master: cover property (@(posedge mclk) arbitration_master);
  c_timeout: cover property (@(posedge mclk) token_timeout);
endmodule

/* File: tb/tra_ring_peer.sv */
`timescale 1ns/1ps
// neighbouring package on the ring plus the management-side byte sink
module tra_ring_peer
  import tra_pkg::*;
(
  // clock
  input wire logic mclk,
  // op-codes toward the block
  output logic ring_opcode_valid,
  output logic [2:0] ring_opcode_in,
  output logic [ID_W-1:0] ring_id_in,
  // receive-data lines from the block
  input wire logic [DATA_W-1:0] rxd_out,
  input wire logic rxd_oe,
  input wire logic [1:0] rxd_kind
);
  logic [DATA_W-1:0] got_q[$];
  // nothing offered before the first op-code
  initial begin
    ring_opcode_valid = 1'b0;
    ring_opcode_in = OP_IDLE;
    ring_id_in = '0;
  end
  // one op-code held for one edge; released lines show inverted junk
  task automatic send_op(input logic [2:0] op, input logic [ID_W-1:0] id);
    @(posedge mclk);
    #1;
    ring_opcode_valid = 1'b1;
    ring_opcode_in = op;
    ring_id_in = id;
    @(posedge mclk);
    #1;
    ring_opcode_valid = 1'b0;
    ring_opcode_in = ~op;
    ring_id_in = ~id;
  endtask
  // management side keeps every packet byte it sees
  always @(posedge mclk) begin
    if (rxd_oe === 1'b1 && rxd_kind === KIND_PKT) begin
      got_q.push_back(rxd_out);
    end
  end
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
  num_errors++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  import tra_pkg::*;
  // design signals
  logic mclk = 1'b0, reset_n = 1'b0, arbitration_enable_event = 1'b0;
  logic congested = 1'b0, pkt_valid = 1'b0, pkt_last = 1'b0;
  logic [DATA_W-1:0] pkt_data = '0;
  logic ring_opcode_valid, pkt_ready, rxd_oe, arbitration_master;
  logic [2:0] ring_opcode_in, ring_opcode_out;
  logic [ID_W-1:0] ring_id_in, ring_id_out;
  logic [DATA_W-1:0] rxd_out;
  logic [1:0] rxd_kind;
  logic [15:0] rxd_pause_time;
  logic transmit_pending, token_timeout, pause_on_frame_done;
  logic pause_off_frame_done, own_resume_opcode_sent;
  logic own_resume_opcode_returned;
  logic [ID_W-1:0] own_id = 2'h1;
  logic [DATA_W-1:0] exp_q[$];
  int num_errors = 0, check_count = 0, pause_on_cnt = 0, n;
  int pause_off_cnt = 0;
  always #2 mclk = ~mclk;
  tra_arbiter DUT (.mclk(mclk), .reset_n(reset_n),
    .package_identifier(own_id),
    .arbitration_enable_event(arbitration_enable_event),
    .congested(congested), .ring_opcode_valid(ring_opcode_valid),
    .ring_opcode_in(ring_opcode_in), .ring_id_in(ring_id_in),
    .ring_opcode_out(ring_opcode_out), .ring_id_out(ring_id_out),
    .pkt_valid(pkt_valid), .pkt_ready(pkt_ready), .pkt_data(pkt_data),
    .pkt_last(pkt_last), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
    .rxd_kind(rxd_kind), .rxd_pause_time(rxd_pause_time),
    .arbitration_master(arbitration_master),
    .transmit_pending(transmit_pending), .token_timeout(token_timeout),
    .pause_on_frame_done(pause_on_frame_done),
    .pause_off_frame_done(pause_off_frame_done),
    .own_resume_opcode_sent(own_resume_opcode_sent),
    .own_resume_opcode_returned(own_resume_opcode_returned));
  tra_ring_peer PEER (.mclk(mclk), .ring_opcode_valid(ring_opcode_valid),
    .ring_opcode_in(ring_opcode_in), .ring_id_in(ring_id_in),
    .rxd_out(rxd_out), .rxd_oe(rxd_oe), .rxd_kind(rxd_kind));
  // verdict and end of run
  task automatic complete_run();
    if (num_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask
  task automatic expect_op(input logic [2:0] op, input int maxc);
    int k;
    k = 0;
    while (ring_opcode_out !== op && k < maxc) begin
      cyc(1);
      k++;
    end
    `CHK("ring_opcode_out", op, ring_opcode_out)
  endtask
  function automatic logic flag(input int s);
    case (s)
      0: return own_resume_opcode_sent;
      1: return own_resume_opcode_returned;
      2: return token_timeout;
      default: return transmit_pending;
    endcase
  endfunction
  task automatic wait_flag(input int s, input int maxc);
    int k;
    k = 0;
    while (flag(s) !== 1'b1 && k < maxc) begin
      cyc(1);
      k++;
    end
    `CHK("status flag", 1'b1, flag(s))
  endtask
  // byte stream into the buffer, held until accepted
  task automatic push_pkt(input int len);
    int k;
    for (int i = 0; i < len; i++) begin
      pkt_data = DATA_W'($urandom);
      pkt_last = (i == len - 1);
      pkt_valid = 1'b1;
      k = 0;
      do begin
        @(posedge mclk);
        k++;
      end while (pkt_ready !== 1'b1 && k < 50);
      #1;
      exp_q.push_back(pkt_data);
    end
    pkt_valid = 1'b0;
  endtask
  // watch one transfer and compare the delivered bytes
  task automatic drain(input bit cong);
    int k;
    k = 0;
    while (rxd_oe !== 1'b1 && k < 20) begin
      cyc(1);
      k++;
    end
    congested = cong;
    // idle op-codes until the token is handed on, gaps included
    while (ring_opcode_out !== OP_TOKEN && k < 80) begin
      `CHK("op during transfer", OP_IDLE, ring_opcode_out)
      cyc(1);
      k++;
    end
    expect_op(OP_TOKEN, 4);
    `CHK("byte count", exp_q.size(), PEER.got_q.size())
    while (exp_q.size() > 0 && PEER.got_q.size() > 0) begin
      `CHK("rxd byte", exp_q.pop_front(), PEER.got_q.pop_front())
    end
    exp_q.delete();
    PEER.got_q.delete();
  endtask
  // pause frames carry the full pause time
  always @(posedge mclk) begin
    if (rxd_oe === 1'b1 && rxd_kind === KIND_XOFF) begin
      `CHK("pause time", PAUSE_MAX, rxd_pause_time)
    end
    if (pause_on_frame_done === 1'b1) begin
      pause_on_cnt++;
    end
    if (pause_off_frame_done === 1'b1) begin
      pause_off_cnt++;
    end
  end
  initial begin
    #(20000 * CLK_NS);
    num_errors++;
    complete_run();
  end
  initial begin
    void'($urandom(32'h11C2));
    repeat (2) @(posedge mclk);
    `CHK("op in reset", OP_FLUSH, ring_opcode_out)
    `CHK("oe in reset", 1'b0, rxd_oe)
    #1;
    reset_n = 1'b1;
    // election lost to a lower identifier
    cyc(2);
    `CHK("flush out", OP_FLUSH, ring_opcode_out)
    PEER.send_op(OP_FLUSH, 2'h3);
    cyc(2);
    `CHK("higher flush ignored", OP_FLUSH, ring_opcode_out)
    PEER.send_op(OP_FLUSH, 2'h0);
    PEER.send_op(OP_IDLE, 2'h0);
    PEER.send_op(OP_TOKEN, 2'h0);
    expect_op(OP_TOKEN, 4);
    `CHK("not master", 1'b0, arbitration_master)
    `CHK("oe normal", 1'b0, rxd_oe)
    // congestion op-codes
    congested = 1'b1;
    expect_op(OP_XOFF, 4);
    congested = 1'b0;
    wait_flag(0, 6);
    `CHK("xon out", OP_XON, ring_opcode_out)
    `CHK("xon id", own_id, ring_id_out)
    PEER.send_op(OP_XON, own_id);
    wait_flag(1, 6);
    // re-election won by this package
    arbitration_enable_event = 1'b1;
    cyc(1);
    arbitration_enable_event = 1'b0;
    expect_op(OP_FLUSH, 4);
    PEER.send_op(OP_FLUSH, own_id);
    expect_op(OP_IDLE, 4);
    `CHK("master", 1'b1, arbitration_master)
    PEER.send_op(OP_IDLE, 2'h0);
    expect_op(OP_TOKEN, 4);
    // full buffer, then a random short packet with congestion
    for (int p = 0; p < 2; p++) begin
      n = (p == 0) ? FIFO_DEPTH : 1 + $urandom % 7;
      push_pkt(n);
      cyc(1);
      if (p == 0) begin
        `CHK("buffer full", 1'b0, pkt_ready)
      end
      wait_flag(3, 4);
      PEER.send_op(OP_TOKEN, 2'h0);
      drain(p == 1);
    end
    PEER.send_op(OP_TOKEN, 2'h0);
    cyc(30);
    `CHK("pause frames", 1, pause_on_cnt)
    `CHK("pause off frames", 1, pause_off_cnt)
    congested = 1'b0;
    cyc(4);
    // token never comes back
    push_pkt(2);
    wait_flag(2, TOKEN_TIMEOUT_CYC + 40);
    expect_op(OP_FLUSH, 4);
    PEER.send_op(OP_FLUSH, own_id);
    PEER.send_op(OP_IDLE, 2'h0);
    drain(1'b0);
    // foreign flush in normal state
    PEER.send_op(OP_FLUSH, 2'h0);
    expect_op(OP_FLUSH, 4);
    complete_run();
  end
endmodule
